// file: logic/pfsa_core.sv
// Core end: turns software register accesses into link operations
`default_nettype none

module pfsa_core (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Software register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdata,
  // Link to the flash end
  pfsa_if.host             link
);
  import pfsa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Write side: each write to a mapped register, except a status write without the done bit, becomes one operation a cycle later
  // Writes while the flash stalls the core are dropped, as a halted core issues none
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link.op_valid <= 1'b0;
      link.op_code  <= OP_PTR;
      link.op_data  <= '0;
    end else begin
      link.op_valid <= 1'b0;
      link.op_data  <= wdata[PTR_W-1:0];
      if (wr && !link.stall) begin // R09 R23
        unique case (addr)
          HR_PTR: begin
            link.op_valid <= 1'b1;
            link.op_code  <= OP_PTR;
          end
          HR_CTRL: begin
            link.op_valid <= 1'b1;
            link.op_code  <= OP_CTRL; // R05 R13
          end
          HR_UNLOCK: begin
            link.op_valid <= 1'b1;
            link.op_code  <= OP_UNLOCK; // R07
          end
          HR_READ: begin
            link.op_valid <= 1'b1;
            link.op_code  <= OP_TABLE_READ_INSTR;
          end
          HR_WRITE: begin
            link.op_valid <= 1'b1;
            link.op_code  <= OP_TABLE_WRITE_INSTR; // R16
          end
          HR_STATUS: begin
            // Writing one to the done bit clears the flag
            link.op_valid <= wdata[STS_DONE];
            link.op_code  <= OP_FLAGCLR; // R19
          end
          default: begin
            link.op_valid <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read side: data stands in the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        HR_PTR:    rdata <= {10'h000, link.byte_pointer};
        HR_CTRL:   rdata <= {24'h000000, link.memory_control_reg};
        HR_READ:   rdata <= {24'h000000, link.read_latch};
        HR_STATUS: rdata <= {14'h0000, link.write_complete_flag, link.stall,
                             link.read_latch, link.memory_control_reg};
        default:   rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule : pfsa_core

`default_nettype wire

// file: logic/pfsa_flash.sv
// Flash end: pointer, read latch, holding registers, unlock and long-cycle sequencer
`default_nettype none

// Overview of operation
// R01: Each table read loads one byte into latch
// R02: Pointer bit zero picks high or low byte
// R03: Erase always clears one 64-byte row
// R04: Erase row from pointer bits 21:6 only; the code takes the row from bits 11:6 alone
// R05: Software sets program select, clears config, enables
// R06: Erase select turns next start into erase
// R07: Start accepted only after 55h then AAh
// R08: Start with erase selected begins row erase
// R09: Core stalls until internal timer ends cycle
// R10: Erase or program lasts about 2 ms
// R11: Programming covers whole 64-byte rows only
// R12: 64 holding registers; table writes skip array
// R13: Control write launches long program of row
// R14: Holding registers return to FFh after reset, write
// R15: Programming only clears bits; FFh keeps byte
// R16: Untouched holding registers leave bytes unchanged
// R17: No bulk erase beyond one row here
// R18: Write start settable only; hardware clears it
// R19: Completion sets sticky flag; software clears it
// R20: Reset mid-cycle or bad start sets error
// R21: Erase select cleared when erase completes
// R22: Unlock must immediately precede start, else nothing
// R23: Software masks interrupts around long cycle
module pfsa_flash #(
  parameter int PROG_CYCLES = pfsa_pkg::PROG_CYCLES  // Self-timed cycle length, shorten in simulation
) (
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  sys_rst,
  // Link to the core
  pfsa_if.device     link,
  // Local status
  output var  logic  array_busy
);
  import pfsa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  pfsa_state_t       state;                      // Sequencer state
  pfsa_unlock_t      unlock;                     // Unlock progress
  logic [TMR_W-1:0]  tmr;                        // Programming timer
  logic [5:0]        row;                        // Row latched at start
  logic [15:0]       flash_mem [FLASH_WORDS];    // Program array, 16-bit words
  logic [7:0]        hold [ROW_BYTES];           // Holding registers
  logic              idle;                       // No long cycle running
  logic              op_ctrl;                    // Control write this cycle
  logic              wr_req;                     // Control write asks to start
  logic              legal;                      // Start conditions all met
  logic              start;                      // Long cycle begins
  logic              done;                       // Timer ends the cycle
  logic [4:0]        widx;                       // Word within row
  logic [FLASH_WORD_AW-1:0] waddr;               // Array word being worked
  logic              rst_d;                      // Reset seen in the previous cycle

  assign idle    = (state == ST_IDLE);
  assign op_ctrl = link.op_valid && idle && (link.op_code == OP_CTRL);
  assign wr_req  = op_ctrl && link.op_data[CTL_WR];
  // Written value is checked, so a single control write may set enables and start
  assign legal   = (unlock == UL_TWO) && link.op_data[CTL_WRITE_ENABLE_BIT] &&
                   link.op_data[CTL_PROG_SEL] && !link.op_data[CTL_CFG_SEL]; // R05 R07 R17
  assign start   = wr_req && legal; // R07 R22 R13
  assign done    = !idle && (tmr == TMR_W'(PROG_CYCLES - 1)); // R09 R10
  assign widx    = tmr[4:0];
  assign waddr   = {row, widx};

  ////////////////////////////////////////////////////////////////////////
  // Byte pointer, loaded only while idle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link.byte_pointer <= '0;
    end else if (link.op_valid && idle && link.op_code == OP_PTR) begin
      link.byte_pointer <= link.op_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unlock tracker: any other operation between steps breaks the chain
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      unlock <= UL_NONE;
    end else if (link.op_valid && idle) begin
      if (link.op_code == OP_UNLOCK && link.op_data[7:0] == UNLOCK_FIRST) begin
        unlock <= UL_ONE; // R07
      end else if (link.op_code == OP_UNLOCK && link.op_data[7:0] == UNLOCK_SECOND &&
                   unlock == UL_ONE) begin
        unlock <= UL_TWO; // R07
      end else begin
        unlock <= UL_NONE; // R22
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset history, so a reset held for many cycles keeps its first verdict
  always_ff @(posedge sys_clk) begin
    rst_d <= sys_rst;
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory control register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link.memory_control_reg          <= CTRL_RESET;
      // Reset is synchronous, so the busy state is still visible at its first edge;
      // later reset edges see idle and must keep the error, not clear it
      link.memory_control_reg[CTL_ERR] <= !idle || (rst_d && link.memory_control_reg[CTL_ERR]); // R20
    end else if (done) begin
      link.memory_control_reg[CTL_WR]        <= 1'b0; // R18
      link.memory_control_reg[CTL_ERASE_SEL] <= 1'b0; // R21
      link.memory_control_reg[CTL_ERR]       <= 1'b0;
    end else if (op_ctrl) begin
      link.memory_control_reg[CTL_PROG_SEL]  <= link.op_data[CTL_PROG_SEL];
      link.memory_control_reg[CTL_CFG_SEL]   <= link.op_data[CTL_CFG_SEL];
      link.memory_control_reg[CTL_ERASE_SEL] <= link.op_data[CTL_ERASE_SEL];
      link.memory_control_reg[CTL_WRITE_ENABLE_BIT]      <= link.op_data[CTL_WRITE_ENABLE_BIT];
      // Select bits take the written value even on a bad start so the cause can be traced
      link.memory_control_reg[CTL_ERR] <= link.op_data[CTL_ERR] | (wr_req && !legal); // R20
      // Start bit can only be set here, never cleared by a write
      link.memory_control_reg[CTL_WR]  <= start; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and programming timer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      tmr   <= '0;
      row   <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          tmr <= '0;
          if (start) begin
            row <= link.byte_pointer[ROW_LSB+5:ROW_LSB]; // R04
            if (link.op_data[CTL_ERASE_SEL]) begin
              state <= ST_ERASE; // R06 R08
            end else begin
              state <= ST_PROG; // R13
            end
          end
        end
        ST_ERASE, ST_PROG: begin
          if (done) begin
            state <= ST_IDLE; // R09
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core stall and local busy, flopped copies of the running cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link.stall <= 1'b0;
      array_busy <= 1'b0;
    end else begin
      link.stall <= start || (!idle && !done); // R09
      array_busy <= start || (!idle && !done);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array work: one word per cycle over the first 32 timer counts
  // Needs PROG_CYCLES of at least ROW_WORDS
  always_ff @(posedge sys_clk) begin
    if (!idle && tmr < TMR_W'(ROW_WORDS)) begin
      if (state == ST_ERASE) begin
        flash_mem[waddr] <= ERASED_WORD; // R03
      end else begin
        // AND with holding data: FFh bytes keep the old contents
        flash_mem[waddr] <= flash_mem[waddr] & {hold[{widx, 1'b1}], hold[{widx, 1'b0}]}; // R11 R15 R16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Table read: one byte per instruction, odd address gives high byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link.read_latch <= '0;
    end else if (link.op_valid && idle && link.op_code == OP_TABLE_READ_INSTR) begin
      if (link.byte_pointer[0]) begin
        link.read_latch <= flash_mem[link.byte_pointer[FLASH_WORD_AW:1]][15:8]; // R01 R02
      end else begin
        link.read_latch <= flash_mem[link.byte_pointer[FLASH_WORD_AW:1]][7:0]; // R01 R02
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Holding registers, addressed by pointer bits 5:0
  for (genvar i = 0; i < ROW_BYTES; i++) begin : g_hold
    always_ff @(posedge sys_clk) begin
      if (sys_rst || done) begin
        hold[i] <= HOLD_RESET; // R14
      end else if (link.op_valid && idle && link.op_code == OP_TABLE_WRITE_INSTR &&
                   link.byte_pointer[5:0] == 6'(i)) begin
        hold[i] <= link.op_data[7:0]; // R12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write complete flag: a completion in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link.write_complete_flag <= 1'b0;
    end else if (done) begin
      link.write_complete_flag <= 1'b1; // R19
    end else if (link.op_valid && link.op_code == OP_FLAGCLR) begin
      link.write_complete_flag <= 1'b0; // R19
    end
  end

endmodule : pfsa_flash

`default_nettype wire

// file: logic/pfsa_if.sv
// Link between the CPU core end and the flash self-access end
`default_nettype none

interface pfsa_if;
  import pfsa_pkg::*;

  // Core to flash
  logic               op_valid;   // One-cycle operation strobe
  pfsa_op_t           op_code;    // Operation kind
  logic [PTR_W-1:0]   op_data;    // Pointer or data byte in low bits
  // Flash to core
  logic [PTR_W-1:0]   byte_pointer;
  logic [7:0]         read_latch;
  logic [7:0]         memory_control_reg;
  logic               stall;      // Core halted while high
  logic               write_complete_flag;

  modport device (
    input  op_valid, op_code, op_data,
    output byte_pointer, read_latch, memory_control_reg, stall, write_complete_flag
  );

  modport host (
    output op_valid, op_code, op_data,
    input  byte_pointer, read_latch, memory_control_reg, stall, write_complete_flag
  );
endinterface : pfsa_if

`default_nettype wire

// file: logic/pfsa_pkg.sv
// Shared constants and types for the program flash self-access path
`default_nettype none

package pfsa_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and self-timed cycle
  localparam int CLK_PERIOD_NS = 25;          // 40 MHz system clock
  localparam int PROG_TIME_NS  = 2_000_000;   // Long write or erase, about 2 ms
  localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W         = 17;          // Wide enough for PROG_CYCLES

  ////////////////////////////////////////////////////////////////////////
  // Pointer and array geometry
  localparam int PTR_W         = 22;          // Byte pointer width
  localparam int ROW_BYTES     = 64;          // Bytes per erase/program row
  localparam int ROW_WORDS     = 32;          // Words per row
  localparam int ROW_LSB       = 6;           // Lowest row-select pointer bit
  localparam int FLASH_WORD_AW = 11;          // Word address bits of the array
  localparam int FLASH_WORDS   = 2048;        // Modelled array depth in words

  ////////////////////////////////////////////////////////////////////////
  // Data values
  localparam logic [7:0]  UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0]  UNLOCK_SECOND = 8'haa;
  localparam logic [7:0]  HOLD_RESET    = 8'hff;
  localparam logic [15:0] ERASED_WORD   = 16'hffff;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Memory control register bit positions
  localparam int CTL_PROG_SEL  = 7;           // program_memory_select
  localparam int CTL_CFG_SEL   = 6;           // config_space_select
  localparam int CTL_ERASE_SEL = 4;           // Row erase select
  localparam int CTL_ERR       = 3;           // write_error_flag
  localparam int CTL_WRITE_ENABLE_BIT      = 2;           // write_enable_bit
  localparam int CTL_WR        = 1;           // Write start

  ////////////////////////////////////////////////////////////////////////
  // Host controller register map and status layout
  localparam logic [7:0] HR_PTR    = 8'h00;
  localparam logic [7:0] HR_CTRL   = 8'h04;
  localparam logic [7:0] HR_UNLOCK = 8'h08;
  localparam logic [7:0] HR_READ   = 8'h0c;
  localparam logic [7:0] HR_WRITE  = 8'h10;
  localparam logic [7:0] HR_STATUS = 8'h14;
  localparam int STS_STALL = 16;              // Status bit: core stalled
  localparam int STS_DONE  = 17;              // Status bit: write complete

  ////////////////////////////////////////////////////////////////////////
  // Operation codes on the link
  typedef enum logic [2:0] {
    OP_PTR     = 3'h0,                        // Load byte pointer
    OP_CTRL    = 3'h1,                        // Write memory control register
    OP_UNLOCK  = 3'h2,                        // Write unlock register
    OP_TABLE_READ_INSTR   = 3'h3,                        // Table read
    OP_TABLE_WRITE_INSTR   = 3'h4,                        // Table write to holding register
    OP_FLAGCLR = 3'h5                         // Clear write complete flag
  } pfsa_op_t;

  // Long-cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROG  = 3'b100
  } pfsa_state_t;

  // Unlock sequence tracker states
  typedef enum logic [2:0] {
    UL_NONE = 3'b001,
    UL_ONE  = 3'b010,
    UL_TWO  = 3'b100
  } pfsa_unlock_t;

endpackage : pfsa_pkg

`default_nettype wire

// file: tb/pfsa_props.sv
// Checker for the link between the core end and the flash end
`default_nettype none

module pfsa_props #(
  parameter int PROG_CYCLES = pfsa_pkg::PROG_CYCLES  // Self-timed cycle length under test
) (
  // Clock and reset
  input wire logic                       sys_clk,
  input wire logic                       sys_rst,
  // Core to flash
  input wire logic                       op_valid,
  input wire pfsa_pkg::pfsa_op_t         op_code,
  input wire logic [pfsa_pkg::PTR_W-1:0] op_data,
  // Flash to core
  input wire logic [pfsa_pkg::PTR_W-1:0] byte_pointer,
  input wire logic [7:0]                 read_latch,
  input wire logic [7:0]                 memory_control_reg,
  input wire logic                       stall,
  input wire logic                       write_complete_flag
);
  import pfsa_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  int         stall_cnt;  // Cycles of the current stall
  logic [1:0] ul;         // Unlock progress: 0 none, 1 first, 2 both
  logic       go;         // Start request while idle
  logic       good_en;    // Enables carried with the start

  // Stall length counter, a 2 ms count is far beyond a repetition
  always_ff @(posedge sys_clk) begin
    stall_cnt <= (sys_rst || !stall) ? 0 : stall_cnt + 1;
  end

  // Unlock tracker; any other operation breaks the sequence
  always_ff @(posedge sys_clk) begin
    if (sys_rst) ul <= 2'd0;
    else if (op_valid) begin
      if (op_code == OP_UNLOCK && op_data[7:0] == UNLOCK_FIRST) ul <= 2'd1;
      else if (op_code == OP_UNLOCK && op_data[7:0] == UNLOCK_SECOND && ul == 2'd1) ul <= 2'd2;
      else ul <= 2'd0;
    end
  end
  assign go = op_valid && op_code == OP_CTRL && op_data[CTL_WR] && !stall && !memory_control_reg[CTL_WR];
  assign good_en = op_data[CTL_PROG_SEL] && !op_data[CTL_CFG_SEL] && op_data[CTL_WRITE_ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////
  sequence s_launch;
    memory_control_reg[CTL_WR] ##1 stall;
  endsequence
  sequence s_refused;
    memory_control_reg[CTL_ERR] && !memory_control_reg[CTL_WR] ##1 !stall;
  endsequence

  property p_start;    go && ul == 2'd2 && good_en |=> s_launch; endproperty
  property p_unlocked; go && ul != 2'd2 |=> s_refused; endproperty
  property p_bad_en;   go && !good_en |=> s_refused; endproperty
  property p_ptr;      op_valid && op_code == OP_PTR && !stall |=> byte_pointer == $past(op_data); endproperty
  property p_len;      $fell(stall) |-> stall_cnt == PROG_CYCLES; endproperty
  property p_flag;     $fell(stall) |-> write_complete_flag; endproperty
  property p_clear;    $fell(stall) |-> !memory_control_reg[CTL_WR] && !memory_control_reg[CTL_ERASE_SEL]; endproperty
  property p_hold;     $rose(stall) |-> $rose(memory_control_reg[CTL_WR]); endproperty
  property p_flagclr;  op_valid && op_code == OP_FLAGCLR && !stall |=> !write_complete_flag; endproperty

  a_start: assert property (p_start) else $error("start after unlock did not launch");
  a_unlocked: assert property (p_unlocked) else $error("start without unlock not refused");
  a_bad_en: assert property (p_bad_en) else $error("start with bad enables not refused");
  a_ptr: assert property (p_ptr) else $error("pointer load lost");
  a_len: assert property (p_len) else $error("stall length wrong");
  a_flag: assert property (p_flag) else $error("completion flag not set");
  a_clear: assert property (p_clear) else $error("start or erase select not cleared");
  a_hold: assert property (p_hold) else $error("stall without start bit");
  a_flagclr: assert property (p_flagclr) else $error("flag clear ignored");
endmodule // pfsa_props

`default_nettype wire

// file: tb/testbench.sv
// Testbench joining the core end and the flash end over the link
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pfsa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  localparam int          PC   = 40;         // Shortened self-timed cycle
  localparam logic [21:0] BASE = 22'h000140; // Row under test
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [7:0]  b;
  logic        busy;                         // Local busy of the flash end
  logic [7:0]  exp_row [64];                 // Expected row contents
  int          bad_count = 0;
  int          cmp_count = 0;
  int          n;

  pfsa_if pfsa_if_inst ();
  pfsa_core pfsa_core_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link(pfsa_if_inst));
  pfsa_flash #(.PROG_CYCLES(PC)) pfsa_flash_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .link(pfsa_if_inst), .array_busy(busy));
  pfsa_props #(.PROG_CYCLES(PC)) pfsa_props_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .op_valid(pfsa_if_inst.op_valid), .op_code(pfsa_if_inst.op_code), .op_data(pfsa_if_inst.op_data),
    .byte_pointer(pfsa_if_inst.byte_pointer), .read_latch(pfsa_if_inst.read_latch),
    .memory_control_reg(pfsa_if_inst.memory_control_reg), .stall(pfsa_if_inst.stall),
    .write_complete_flag(pfsa_if_inst.write_complete_flag));

  // 40 MHz clock
  initial forever #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("Error %0t ns: got %h want %h", $time, got, want);
    end
  endtask

  // One-cycle write strobe; a gap cycle follows
  task bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task rd_byte(input logic [21:0] p, output logic [7:0] v);
    bus_wr(HR_PTR, {10'h000, p});
    bus_wr(HR_READ, 32'h0);
    bus_rd(HR_READ, d);
    v = d[7:0];
  endtask

  // Control, unlock pair, then start bit
  task start(input logic [7:0] c);
    bus_wr(HR_CTRL, {24'h0, c & 8'hfd});
    bus_wr(HR_UNLOCK, {24'h0, UNLOCK_FIRST});
    bus_wr(HR_UNLOCK, {24'h0, UNLOCK_SECOND});
    bus_wr(HR_CTRL, {24'h0, c | 8'h02});
  endtask

  // Holding register load; programming can only clear bits
  task hold(input logic [5:0] o, input logic [7:0] v);
    bus_wr(HR_PTR, {10'h000, BASE | {16'h0, o}});
    bus_wr(HR_WRITE, {24'h0, v});
    exp_row[o] = exp_row[o] & v;
  endtask

  // Waits out the long cycle and checks its outcome
  task finish_long(input logic [7:0] ctl);
    @(posedge sys_clk);
    bus_rd(HR_STATUS, d);
    chk(d[STS_STALL], 1'b1);
    chk(busy, 1'b1);
    n = 0;
    while (pfsa_if_inst.stall === 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(n > PC - 8 && n <= PC, 1'b1);
    chk(busy, 1'b0);
    bus_rd(HR_STATUS, d);
    chk(d[STS_DONE], 1'b1);
    chk(d[7:0], ctl);
    bus_wr(HR_STATUS, 32'h1 << STS_DONE);
    bus_rd(HR_STATUS, d);
    chk(d[STS_DONE], 1'b0);
  endtask

  task chk_row;
    for (int i = 0; i < 64; i++) begin
      rd_byte(22'(BASE + i), b);
      chk(b, exp_row[i]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Erase with pointer inside the row: whole row must clear
  task erase_row;
    bus_wr(HR_PTR, {10'h000, BASE + 22'h17});
    bus_rd(HR_PTR, d);
    chk(d, {10'h000, BASE + 22'h17});
    start(8'h94);
    finish_long(8'h84);
    foreach (exp_row[i]) exp_row[i] = HOLD_RESET;
    chk_row();
    $display("test erase done");
  endtask

  task t_prog;
    hold(6'd0, 8'h3c);
    hold(6'd1, 8'ha5);
    hold(6'd42, 8'h5a);
    hold(6'd63, 8'h00);
    rd_byte(BASE, b);
    chk(b, HOLD_RESET);
    start(8'h84);
    finish_long(8'h84);
    chk_row();
    hold(6'd0, 8'hf0);
    start(8'h84);
    finish_long(8'h84);
    chk_row();
    erase_row();
    hold(6'd2, 8'h7e);
    start(8'h84);
    finish_long(8'h84);
    chk_row();
    $display("test program done");
  endtask

  // Broken unlock, swapped unlock, no write enable, config select
  task t_refuse;
    for (int k = 0; k < 4; k++) begin
      bus_wr(HR_CTRL, 32'h84);
      if (k == 0) begin
        bus_wr(HR_UNLOCK, {24'h0, UNLOCK_FIRST});
        bus_wr(HR_PTR, {10'h000, BASE});
        bus_wr(HR_UNLOCK, {24'h0, UNLOCK_SECOND});
      end
      if (k == 1) begin
        bus_wr(HR_UNLOCK, {24'h0, UNLOCK_SECOND});
        bus_wr(HR_UNLOCK, {24'h0, UNLOCK_FIRST});
      end
      if (k < 2) bus_wr(HR_CTRL, 32'h86);
      else start(k == 2 ? 8'h82 : 8'hc6);
      repeat (3) @(posedge sys_clk);
      bus_rd(HR_STATUS, d);
      chk(d[STS_STALL], 1'b0);
      chk(d[CTL_ERR], 1'b1);
      chk(d[CTL_PROG_SEL], 1'b1);
      chk(d[CTL_CFG_SEL], k == 3);
    end
    chk_row();
    bus_rd(HR_STATUS, d);
    chk(d[15:8], exp_row[63]);
    bus_rd(8'h20, d);
    chk(d, 32'h0);
    $display("test refuse done");
  endtask

  // Reset in mid-cycle leaves the error bit set
  task t_reset;
    hold(6'd5, 8'h00);
    start(8'h84);
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    bus_rd(HR_STATUS, d);
    chk(d[STS_STALL], 1'b0);
    chk(d[CTL_ERR], 1'b1);
    $display("test reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    erase_row();
    t_prog();
    t_refuse();
    t_reset();
    finish_test();
  end

  // Watchdog, the tests need under a tenth of this
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    $display("Error %0t ns: watchdog expired", $time);
    finish_test();
  end
endmodule // testbench

`default_nettype wire
